// ---- pkg/acr_pkg.sv ----
/*
 audio control three register: offsets, field positions, reset values.
 assumes a 100 MHz core clock and an axi4-lite register bus.
*/
// How it works
// - link codes 00 and 11 keep left and right DAC volumes independent.
// - link code 01 drives left DAC gain from the right volume value.
// - link code 10 drives right DAC gain from the left volume value.
// - one-bit reference rate select, 0 is 48.0 kHz, 1 is 44.1 kHz, reset 0.
// - rate select also picks the measurement divider, 16 at 48.0 kHz, 15 at 44.1 kHz.
// - transfer mode bit, 0 continuous, 1 the 256-s mode, reset 0.
// - role bit, 0 slave, 1 master, reset slave.
// - two-bit DAC swing field, four codes from 2.0 V up to 2.633 V.
// - ADC overflow flag sets when ADC data leaves saturation limits.
// - left DAC overflow flag sets when left DAC data saturates.
// - right DAC overflow flag sets when right DAC data saturates.
// - overflow flags stick and clear only when software reads the register.
// - two-bit AGC noise threshold, -60 to -90 dB; below it no AGC chase.
// - AGC clip-stepping enable bit, reset 0.
package acr_pkg;
	localparam logic [7:0] ACR_OFF_CTRL3 = 8'h06;
	localparam logic [7:0] ACR_OFF_VOL = 8'h0C;
	// byte addresses, four times the register index
	localparam logic [7:0] ACR_ADDR_CTRL3 = {ACR_OFF_CTRL3[5:0], 2'h0};
	localparam logic [7:0] ACR_ADDR_VOL = {ACR_OFF_VOL[5:0], 2'h0};
	localparam int ACR_POS_LINK = 14;
	localparam int ACR_POS_RATE = 13;
	localparam int ACR_POS_XFER = 12;
	localparam int ACR_POS_ROLE = 11;
	localparam int ACR_POS_SWING = 9;
	localparam int ACR_POS_AOVF = 8;
	localparam int ACR_POS_LOVF = 7;
	localparam int ACR_POS_ROVF = 6;
	localparam int ACR_POS_NOISE = 4;
	localparam int ACR_POS_CLIP = 3;
	localparam logic [15:0] ACR_RW_MASK = 16'hFE38;
	localparam logic [15:0] ACR_CTRL3_RESET = 16'h0000;
	localparam logic [15:0] ACR_VOL_RESET = 16'h0000;
	localparam logic [2:0] ACR_RSVD_VALUE = 3'h0;
	localparam logic [1:0] ACR_LINK_R2L = 2'h1;
	localparam logic [1:0] ACR_LINK_L2R = 2'h2;
	localparam int ACR_DIV_48K = 16;
	localparam int ACR_DIV_44K = 15;
	localparam logic [1:0] ACR_RESP_OKAY = 2'h0;
	localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;
endpackage : acr_pkg

// ---- rtl/acr_vol_route.sv ----
/*
 dac volume routing by the link field.
 assumes volumes come from the register bank on the same clock.
*/
`timescale 1ns/1ns
module acr_vol_route (
	input wire logic [1:0] link_i,
	input wire logic [7:0] left_vol_i,
	input wire logic [7:0] right_vol_i,
	output logic [7:0] left_gain_o,
	output logic [7:0] right_gain_o
);
	always_comb
	begin
		left_gain_o = left_vol_i;
		right_gain_o = right_vol_i;
		if (link_i == acr_pkg::ACR_LINK_R2L)
		begin
			left_gain_o = right_vol_i;
		end
		else if (link_i == acr_pkg::ACR_LINK_L2R)
		begin
			right_gain_o = left_vol_i;
		end
	end
endmodule : acr_vol_route

// ---- rtl/acr_regs.sv ----
/*
 audio control three register bank with axi4-lite slave.
 assumes overflow events are one-clock pulses from the same clock domain.
*/
`timescale 1ns/1ns
module acr_regs (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic adc_overflow_i,
	input wire logic dac_left_overflow_i,
	input wire logic dac_right_overflow_i,
	output logic [7:0] dac_left_gain_o,
	output logic [7:0] dac_right_gain_o,
	output logic reference_rate_select_o,
	output logic [4:0] meas_clk_div_o,
	output logic master_transfer_mode_o,
	output logic codec_role_select_o,
	output logic [1:0] dac_swing_select_o,
	output logic [1:0] agc_noise_threshold_o,
	output logic agc_clip_step_enable_o
);
	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] vol;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} acr_state_t;

	acr_state_t cur;
	acr_state_t nxt;

	function automatic logic [15:0] acr_merge(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb,
		input logic [15:0] mask);
		logic [15:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
		acr_merge = (old & ~lanes) | (data[15:0] & lanes);
	endfunction : acr_merge

	logic do_write;
	logic do_read;
	logic ctrl_wr;
	logic ctrl_rd;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [15:0] ovf_set;

	assign s_axi_awready = !cur.aw_held && !cur.bvalid;
	assign s_axi_wready = !cur.w_held && !cur.bvalid;
	assign s_axi_arready = !cur.rvalid;
	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp = cur.bresp;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rresp = cur.rresp;
	assign s_axi_rdata = cur.rdata;

	always_comb
	begin
		wr_addr = cur.aw_held ? cur.aw_addr : s_axi_awaddr;
		wr_data = cur.w_held ? cur.w_data : s_axi_wdata;
		wr_strb = cur.w_held ? cur.w_strb : s_axi_wstrb;
		do_write = (cur.aw_held || (s_axi_awvalid && s_axi_awready))
			&& (cur.w_held || (s_axi_wvalid && s_axi_wready));
		do_read = s_axi_arvalid && s_axi_arready;
		ctrl_wr = do_write && wr_addr == acr_pkg::ACR_ADDR_CTRL3;
		ctrl_rd = do_read && s_axi_araddr == acr_pkg::ACR_ADDR_CTRL3;
		ovf_set = 16'h0000;
		ovf_set[acr_pkg::ACR_POS_AOVF] = adc_overflow_i;
		ovf_set[acr_pkg::ACR_POS_LOVF] = dac_left_overflow_i;
		ovf_set[acr_pkg::ACR_POS_ROVF] = dac_right_overflow_i;
	end

	always_comb
	begin
		nxt = cur;
		if (s_axi_awvalid && s_axi_awready && !do_write)
		begin
			nxt.aw_held = 1'b1;
			nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready && !do_write)
		begin
			nxt.w_held = 1'b1;
			nxt.w_data = s_axi_wdata;
			nxt.w_strb = s_axi_wstrb;
		end
		if (cur.bvalid && s_axi_bready)
		begin
			nxt.bvalid = 1'b0;
		end
		if (cur.rvalid && s_axi_rready)
		begin
			nxt.rvalid = 1'b0;
		end
		if (do_write)
		begin
			nxt.aw_held = 1'b0;
			nxt.w_held = 1'b0;
			nxt.bvalid = 1'b1;
			nxt.bresp = acr_pkg::ACR_RESP_OKAY;
			if (ctrl_wr)
			begin
				nxt.ctrl = acr_merge(cur.ctrl, wr_data, wr_strb,
					acr_pkg::ACR_RW_MASK);
			end
			else if (wr_addr == acr_pkg::ACR_ADDR_VOL)
			begin
				nxt.vol = acr_merge(cur.vol, wr_data, wr_strb, 16'hFFFF);
			end
			else
			begin
				nxt.bresp = acr_pkg::ACR_RESP_SLVERR;
			end
		end
		if (do_read)
		begin
			nxt.rvalid = 1'b1;
			nxt.rresp = acr_pkg::ACR_RESP_OKAY;
			nxt.rdata = 32'h0000_0000;
			if (ctrl_rd)
			begin
				nxt.rdata[15:0] = {cur.ctrl[15:3] | ovf_set[15:3],
					acr_pkg::ACR_RSVD_VALUE};
				nxt.ctrl = nxt.ctrl & acr_pkg::ACR_RW_MASK;
			end
			else if (s_axi_araddr == acr_pkg::ACR_ADDR_VOL)
			begin
				nxt.rdata[15:0] = cur.vol;
			end
			else
			begin
				nxt.rresp = acr_pkg::ACR_RESP_SLVERR;
			end
		end
		nxt.ctrl = nxt.ctrl | ovf_set;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			cur <= '0;
			cur.ctrl <= acr_pkg::ACR_CTRL3_RESET;
			cur.vol <= acr_pkg::ACR_VOL_RESET;
		end
		else
		begin
			cur <= nxt;
		end
	end

	acr_vol_route u_route (
		.link_i(cur.ctrl[acr_pkg::ACR_POS_LINK +: 2]),
		.left_vol_i(cur.vol[15:8]),
		.right_vol_i(cur.vol[7:0]),
		.left_gain_o(dac_left_gain_o),
		.right_gain_o(dac_right_gain_o)
	);

	assign reference_rate_select_o = cur.ctrl[acr_pkg::ACR_POS_RATE];
	assign meas_clk_div_o = reference_rate_select_o ?
		5'(acr_pkg::ACR_DIV_44K) : 5'(acr_pkg::ACR_DIV_48K);
	assign master_transfer_mode_o = cur.ctrl[acr_pkg::ACR_POS_XFER];
	assign codec_role_select_o = cur.ctrl[acr_pkg::ACR_POS_ROLE];
	assign dac_swing_select_o = cur.ctrl[acr_pkg::ACR_POS_SWING +: 2];
	assign agc_noise_threshold_o =
		cur.ctrl[acr_pkg::ACR_POS_NOISE +: 2];
	assign agc_clip_step_enable_o = cur.ctrl[acr_pkg::ACR_POS_CLIP];

	chk_flag_sticky: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		cur.ctrl[acr_pkg::ACR_POS_AOVF] && !ctrl_rd
		|=> cur.ctrl[acr_pkg::ACR_POS_AOVF])
		else $error("adc flag lost");
	chk_left_sticky: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		cur.ctrl[acr_pkg::ACR_POS_LOVF] && !ctrl_rd
		|=> cur.ctrl[acr_pkg::ACR_POS_LOVF])
		else $error("left flag lost");
	chk_right_sticky: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		cur.ctrl[acr_pkg::ACR_POS_ROVF] && !ctrl_rd
		|=> cur.ctrl[acr_pkg::ACR_POS_ROVF])
		else $error("right flag lost");
	chk_flag_set: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		dac_left_overflow_i |=> cur.ctrl[acr_pkg::ACR_POS_LOVF])
		else $error("left flag not set");
	chk_flag_rset: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		dac_right_overflow_i |=> cur.ctrl[acr_pkg::ACR_POS_ROVF])
		else $error("right flag not set");
	chk_adc_set: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		adc_overflow_i |=> cur.ctrl[acr_pkg::ACR_POS_AOVF])
		else $error("adc flag not set");
	chk_read_clear: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_rd && !adc_overflow_i
		|=> !cur.ctrl[acr_pkg::ACR_POS_AOVF])
		else $error("adc flag not cleared");
	chk_left_clear: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_rd && !dac_left_overflow_i
		|=> !cur.ctrl[acr_pkg::ACR_POS_LOVF])
		else $error("left flag not cleared");
	chk_right_clear: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_rd && !dac_right_overflow_i
		|=> !cur.ctrl[acr_pkg::ACR_POS_ROVF])
		else $error("right flag not cleared");
	chk_flags_kept: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_wr && !ctrl_rd && ovf_set == 16'h0000
		|=> cur.ctrl[acr_pkg::ACR_POS_ROVF +: 3]
		== $past(cur.ctrl[acr_pkg::ACR_POS_ROVF +: 3]))
		else $error("write reached flag bits");
	chk_rsvd_zero: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		cur.ctrl[2:0] == 3'h0)
		else $error("reserved bits set");
	chk_rsvd_read: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		s_axi_rvalid |-> s_axi_rdata[2:0] == acr_pkg::ACR_RSVD_VALUE)
		else $error("reserved bits read nonzero");
	chk_link_indep: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		cur.ctrl[acr_pkg::ACR_POS_LINK +: 2] inside {2'h0, 2'h3}
		|-> dac_left_gain_o == cur.vol[15:8]
		&& dac_right_gain_o == cur.vol[7:0])
		else $error("volumes not independent");
	chk_link_r2l: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		cur.ctrl[acr_pkg::ACR_POS_LINK +: 2] == acr_pkg::ACR_LINK_R2L
		|-> dac_left_gain_o == cur.vol[7:0]
		&& dac_right_gain_o == cur.vol[7:0])
		else $error("left not following right");
	chk_link_l2r: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		cur.ctrl[acr_pkg::ACR_POS_LINK +: 2] == acr_pkg::ACR_LINK_L2R
		|-> dac_right_gain_o == cur.vol[15:8]
		&& dac_left_gain_o == cur.vol[15:8])
		else $error("right not following left");
	chk_div_rate: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		reference_rate_select_o |-> meas_clk_div_o == 5'h0F)
		else $error("divider wrong for 44.1 kHz");
	chk_div_48k: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		!reference_rate_select_o |-> meas_clk_div_o == 5'h10)
		else $error("divider wrong for 48 kHz");
	chk_ctrl_reset: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		$past(reset_i) |-> cur.ctrl == acr_pkg::ACR_CTRL3_RESET)
		else $error("control not at reset value");
	chk_rate_write: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_wr && wr_strb[1] |=> reference_rate_select_o
		== $past(wr_data[acr_pkg::ACR_POS_RATE]))
		else $error("rate select not written");
	chk_xfer_write: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_wr && wr_strb[1] |=> master_transfer_mode_o
		== $past(wr_data[acr_pkg::ACR_POS_XFER]))
		else $error("transfer mode not written");
	chk_role_write: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_wr && wr_strb[1] |=> codec_role_select_o
		== $past(wr_data[acr_pkg::ACR_POS_ROLE]))
		else $error("role select not written");
	chk_swing_write: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_wr && wr_strb[1] |=> dac_swing_select_o
		== $past(wr_data[acr_pkg::ACR_POS_SWING +: 2]))
		else $error("swing select not written");
	chk_noise_write: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_wr && wr_strb[0] |=> agc_noise_threshold_o
		== $past(wr_data[acr_pkg::ACR_POS_NOISE +: 2]))
		else $error("noise threshold not written");
	chk_clip_write: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_wr && wr_strb[0] |=> agc_clip_step_enable_o
		== $past(wr_data[acr_pkg::ACR_POS_CLIP]))
		else $error("clip stepping not written");
endmodule : acr_regs

// ---- verif/tb.sv ----
/*
 bench for the audio control three register bank over axi4-lite.
 assumes the byte offsets and field masks of acr_pkg.
*/
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
$display("BAD %s exp %h got %h", n, e, s); end end
module tb;
	logic ref_clk_i = 0;
	logic reset_i = 1;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, sw, nz;
	logic [31:0] s_axi_rdata, rd_v;
	logic [1:0] rd_r, wr_r;
	logic [2:0] ovf = 0;
	logic [7:0] lg, rg;
	logic [4:0] meas_clk_div_o;
	logic reference_rate_select_o, master_transfer_mode_o;
	logic codec_role_select_o, agc_clip_step_enable_o;
	int failures = 0, compares = 0;
	acr_regs dut (.ref_clk_i, .reset_i, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.adc_overflow_i(ovf[2]), .dac_left_overflow_i(ovf[1]),
		.dac_right_overflow_i(ovf[0]), .dac_left_gain_o(lg),
		.dac_right_gain_o(rg), .reference_rate_select_o, .meas_clk_div_o,
		.master_transfer_mode_o, .codec_role_select_o,
		.dac_swing_select_o(sw), .agc_noise_threshold_o(nz),
		.agc_clip_step_enable_o);
	initial
	begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1;
		w = 1;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (aw || w)
		begin
			@(posedge ref_clk_i);
			if (aw && s_axi_awready === 1)
			begin
				aw = 0;
				s_axi_awvalid <= 0;
			end
			if (w && s_axi_wready === 1)
			begin
				w = 0;
				s_axi_wvalid <= 0;
			end
		end
		while (s_axi_bvalid !== 1) @(posedge ref_clk_i);
		wr_r = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge ref_clk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge ref_clk_i); while (s_axi_arready !== 1);
		s_axi_arvalid <= 0;
		while (s_axi_rvalid !== 1) @(posedge ref_clk_i);
		rd_v = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge ref_clk_i);
	endtask : rd
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	initial
	begin
		#200000;
		failures++;
		give_verdict();
	end
	initial
	begin
		repeat (6) @(posedge ref_clk_i);
		reset_i <= 0;
		rd(acr_pkg::ACR_ADDR_CTRL3);
		`CHK("reset", 32'h0000_0000, rd_v)
		`CHK("div48", 5'h10, meas_clk_div_o)
		$display("reset test done");
		wr(acr_pkg::ACR_ADDR_CTRL3, 32'h0000_ffff);
		`CHK("wresp", acr_pkg::ACR_RESP_OKAY, wr_r)
		rd(acr_pkg::ACR_ADDR_CTRL3);
		`CHK("masked", 32'h0000_fe38, rd_v)
		`CHK("fields", 8'hff, {reference_rate_select_o, master_transfer_mode_o,
			codec_role_select_o, sw, nz, agc_clip_step_enable_o})
		`CHK("div44", 5'h0f, meas_clk_div_o)
		$display("field test done");
		reset_i <= 1;
		repeat (2) @(posedge ref_clk_i);
		reset_i <= 0;
		rd(acr_pkg::ACR_ADDR_CTRL3);
		`CHK("rereset", 32'h0000_0000, rd_v)
		`CHK("rediv", 5'h10, meas_clk_div_o)
		$display("mid-run reset test done");
		wr(acr_pkg::ACR_ADDR_VOL, 32'h0000_ab12);
		for (int i = 0; i < 4; i++)
		begin
			wr(acr_pkg::ACR_ADDR_CTRL3, 32'(i) << 14);
			`CHK("left", (i == 1) ? 8'h12 : 8'hab, lg)
			`CHK("right", (i == 2) ? 8'hab : 8'h12, rg)
		end
		$display("link test done");
		for (int k = 0; k < 3; k++)
		begin
			@(posedge ref_clk_i);
			ovf <= 3'h4 >> k;
			@(posedge ref_clk_i);
			ovf <= 0;
			wr(acr_pkg::ACR_ADDR_CTRL3, 32'h0000_0000);
			rd(acr_pkg::ACR_ADDR_CTRL3);
			`CHK("flag", 32'h0000_0100 >> k, rd_v)
			rd(acr_pkg::ACR_ADDR_CTRL3);
			`CHK("cleared", 32'h0000_0000, rd_v)
		end
		$display("overflow test done");
		rd(8'h20);
		`CHK("badresp", acr_pkg::ACR_RESP_SLVERR, rd_r)
		`CHK("baddata", 32'h0000_0000, rd_v)
		wr(8'h20, 32'h0000_ffff);
		`CHK("badwresp", acr_pkg::ACR_RESP_SLVERR, wr_r)
		rd(acr_pkg::ACR_ADDR_CTRL3);
		`CHK("untouched", 32'h0000_0000, rd_v)
		$display("unmapped test done");
		give_verdict();
	end
endmodule : tb
